// ==== logic/rtac_pkg.sv ====
// Constants for the retimer address and rate configuration block
package rtac_pkg;

  // ****************************************
  // Bus addressing
  // ****************************************
  localparam logic [6:0] RTAC_ADDR_BASE = 7'h18;
  localparam logic [6:0] RTAC_ADDR_RST = 7'h18;
  localparam int RTAC_STRAP_W = 4;
  localparam int RTAC_RW_BIT = 0;
  localparam logic RTAC_DIR_WRITE = 1'b0;
  localparam logic RTAC_DIR_READ = 1'b1;

  // ****************************************
  // Register offsets and reset values
  // ****************************************
  localparam logic [7:0] RTAC_OFS_STD_SEL = 8'h2f;
  localparam logic [7:0] RTAC_OFS_G0_LO = 8'h60;
  localparam logic [7:0] RTAC_OFS_G0_HI = 8'h61;
  localparam logic [7:0] RTAC_OFS_G1_LO = 8'h62;
  localparam logic [7:0] RTAC_OFS_G1_HI = 8'h63;
  localparam logic [7:0] RTAC_OFS_TOL = 8'h64;
  localparam logic [7:0] RTAC_RST_STD_SEL = 8'h00;
  localparam logic [7:0] RTAC_RST_COUNT = 8'h00;
  localparam logic [7:0] RTAC_RST_TOL = 8'h00;
  localparam logic [7:0] RTAC_UNMAPPED_RD = 8'h00;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int RTAC_STD_NIB_LSB = 4;
  localparam int RTAC_MANUAL_BIT = 7;
  localparam int RTAC_TOL_G0_LSB = 0;
  localparam int RTAC_TOL_G1_LSB = 4;
  localparam int RTAC_COUNT_W = 15;

  // ****************************************
  // Divider ratio masks {8,4,2,1}
  // ****************************************
  localparam logic [3:0] RTAC_DIV_1 = 4'h1;
  localparam logic [3:0] RTAC_DIV_2 = 4'h2;
  localparam logic [3:0] RTAC_DIV_8 = 4'h8;
  localparam logic [3:0] RTAC_DIV_124 = 4'h7;
  localparam logic [3:0] RTAC_DIV_24 = 4'h6;
  localparam logic [3:0] RTAC_DIV_14 = 4'h5;
  localparam logic [3:0] RTAC_DIV_1248 = 4'hf;

  // ****************************************
  // Standard-select upper nibble codes
  // ****************************************
  localparam logic [3:0] RTAC_STD_AUTO_ETH = 4'h0;
  localparam logic [3:0] RTAC_STD_FC = 4'h1;
  localparam logic [3:0] RTAC_STD_IB = 4'h2;
  localparam logic [3:0] RTAC_STD_4 = 4'h4;
  localparam logic [3:0] RTAC_STD_SONET = 4'h5;
  localparam logic [3:0] RTAC_STD_6 = 4'h6;
  localparam logic [3:0] RTAC_STD_RATE_A = 4'h7;
  localparam logic [3:0] RTAC_STD_RATE_B = 4'h8;
  localparam logic [3:0] RTAC_STD_A = 4'ha;
  localparam logic [3:0] RTAC_STD_C = 4'hc;
  localparam logic [3:0] RTAC_STD_D = 4'hd;

  // ****************************************
  // Serial slave states
  // ****************************************
  typedef enum logic [8:0] {
    RTAC_ST_IDLE = 9'h001,
    RTAC_ST_ADDR = 9'h002,
    RTAC_ST_AACK = 9'h004,
    RTAC_ST_PTR = 9'h008,
    RTAC_ST_PACK = 9'h010,
    RTAC_ST_WR = 9'h020,
    RTAC_ST_WACK = 9'h040,
    RTAC_ST_RD = 9'h080,
    RTAC_ST_RACK = 9'h100
  } rtac_state_t;

endpackage

// ==== logic/rtac_config.sv ====
// Address strap capture, serial register slave and rate configuration
`timescale 1ns/1ps
`default_nettype none

// Function
// - Capture strap levels once after power-up; keep that address until next power-up.
// - Seven-bit address is 0x18 plus strap value, sixteen addresses in all.
// - Lowest bit of address byte selects write (0) or read (1).
// - Slave mode with load gate high: ignore straps, answer write address 0x30.
// - After capture, all configuration registers are readable and writable over serial bus.
// - Standard-select value restricts the coarse tuning search to that standard's set.
// - Selected standard limits the divider to its allowed ratios.
// - Upper nibble zero selects divider and tuning automatically for 10.3125/1.25 rates.
// - Shared-VCO standards switch divider ratios without register changes.
// - Expected count and tolerance decide whether valid frequency lock exists.
// - Two count groups at 0x60/0x61 and 0x62/0x63, per-group tolerances at 0x64.
// - Combined ethernet mode uses divide ratio 8 for the 1.25 Gb/s group.
// - Count low byte in lower register, high bits 6:0 above, bit 7 manual flag.
// - Tolerance register holds two four-bit tolerances, one per nibble.
module rtac_config
  import rtac_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [RTAC_STRAP_W-1:0] addr_strap_inputs_i,
  input wire logic bus_mode_select_pin_i,
  input wire logic load_gate_i,
  input wire logic serial_clock_line_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic meas_valid_i,
  input wire logic meas_group_i,
  input wire logic [RTAC_COUNT_W-1:0] meas_count_i,
  output logic [6:0] slave_addr_o,
  output logic [3:0] tune_set_o,
  output logic auto_rate_o,
  output logic [3:0] div_group0_o,
  output logic [3:0] div_group1_o,
  output logic [1:0] count_manual_o,
  output logic freq_lock_o
);

  // ****************************************
  // Address capture
  // ****************************************
  logic cap_done_q;
  logic [6:0] slave_addr_q;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cap_done_q <= 1'b0;
      slave_addr_q <= RTAC_ADDR_RST;
    end
    else if (!cap_done_q)
    begin
      cap_done_q <= 1'b1;
      if (bus_mode_select_pin_i && load_gate_i)
        slave_addr_q <= RTAC_ADDR_BASE;
      else
        slave_addr_q <= RTAC_ADDR_BASE + {3'h0, addr_strap_inputs_i};
    end
  end

  assign slave_addr_o = slave_addr_q;

  // ****************************************
  // Serial line edges
  // ****************************************
  logic scl_q, sda_q;
  logic scl_rise, scl_fall, bus_start, bus_stop;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end
    else
    begin
      scl_q <= serial_clock_line_i;
      sda_q <= sda_i;
    end
  end

  assign scl_rise = serial_clock_line_i && !scl_q;
  assign scl_fall = !serial_clock_line_i && scl_q;
  assign bus_start = serial_clock_line_i && scl_q && sda_q && !sda_i;
  assign bus_stop = serial_clock_line_i && scl_q && !sda_q && sda_i;

  // ****************************************
  // Register file
  // ****************************************
  logic [7:0] std_q, g0_lo_q, g0_hi_q, g1_lo_q, g1_hi_q, tol_q;
  logic [7:0] ptr_q, shift_q, rdata;
  logic [7:0] byte_in;
  logic wr_en;

  assign byte_in = {shift_q[6:0], sda_i};

  always_comb
  begin
    unique case (ptr_q)
      RTAC_OFS_STD_SEL: rdata = std_q;
      RTAC_OFS_G0_LO: rdata = g0_lo_q;
      RTAC_OFS_G0_HI: rdata = g0_hi_q;
      RTAC_OFS_G1_LO: rdata = g1_lo_q;
      RTAC_OFS_G1_HI: rdata = g1_hi_q;
      RTAC_OFS_TOL: rdata = tol_q;
      default: rdata = RTAC_UNMAPPED_RD;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      std_q <= RTAC_RST_STD_SEL;
      g0_lo_q <= RTAC_RST_COUNT;
      g0_hi_q <= RTAC_RST_COUNT;
      g1_lo_q <= RTAC_RST_COUNT;
      g1_hi_q <= RTAC_RST_COUNT;
      tol_q <= RTAC_RST_TOL;
    end
    else if (wr_en)
    begin
      unique case (ptr_q)
        RTAC_OFS_STD_SEL: std_q <= byte_in;
        RTAC_OFS_G0_LO: g0_lo_q <= byte_in;
        RTAC_OFS_G0_HI: g0_hi_q <= byte_in;
        RTAC_OFS_G1_LO: g1_lo_q <= byte_in;
        RTAC_OFS_G1_HI: g1_hi_q <= byte_in;
        RTAC_OFS_TOL: tol_q <= byte_in;
        default: ;
      endcase
    end
  end

  // ****************************************
  // Serial slave
  // ****************************************
  rtac_state_t st_q;
  logic [2:0] cnt_q;
  logic ack_ph_q, rw_q, nack_q, sda_out_q;

  assign wr_en = (st_q == RTAC_ST_WR) && scl_rise && (cnt_q == 3'h7);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st_q <= RTAC_ST_IDLE;
      cnt_q <= 3'h0;
      ack_ph_q <= 1'b0;
      rw_q <= 1'b0;
      nack_q <= 1'b0;
      ptr_q <= 8'h00;
      shift_q <= 8'h00;
      sda_oe_o <= 1'b0;
    end
    else if (bus_start && cap_done_q)
    begin
      st_q <= RTAC_ST_ADDR;
      cnt_q <= 3'h0;
      sda_oe_o <= 1'b0;
    end
    else if (bus_stop)
    begin
      st_q <= RTAC_ST_IDLE;
      sda_oe_o <= 1'b0;
    end
    else
    begin
      unique case (st_q)
        RTAC_ST_IDLE: ;
        RTAC_ST_ADDR, RTAC_ST_PTR, RTAC_ST_WR:
          if (scl_rise)
          begin
            shift_q <= byte_in;
            cnt_q <= cnt_q + 3'h1;
            ack_ph_q <= 1'b0;
            if (cnt_q == 3'h7)
            begin
              if (st_q == RTAC_ST_ADDR)
              begin
                rw_q <= sda_i;
                st_q <= (shift_q[6:0] == slave_addr_q) ? RTAC_ST_AACK : RTAC_ST_IDLE;
              end
              else if (st_q == RTAC_ST_PTR)
              begin
                ptr_q <= byte_in;
                st_q <= RTAC_ST_PACK;
              end
              else
              begin
                ptr_q <= ptr_q + 8'h01;
                st_q <= RTAC_ST_WACK;
              end
            end
          end
        RTAC_ST_AACK, RTAC_ST_PACK, RTAC_ST_WACK:
          if (scl_fall)
          begin
            ack_ph_q <= 1'b1;
            sda_oe_o <= !ack_ph_q;
            if (ack_ph_q)
            begin
              cnt_q <= 3'h0;
              if (st_q == RTAC_ST_AACK && rw_q == RTAC_DIR_READ)
              begin
                st_q <= RTAC_ST_RD;
                shift_q <= rdata;
                sda_oe_o <= !rdata[7];
              end
              else
                st_q <= (st_q == RTAC_ST_AACK) ? RTAC_ST_PTR : RTAC_ST_WR;
            end
          end
        RTAC_ST_RD:
          if (scl_fall)
          begin
            if (cnt_q == 3'h7)
            begin
              sda_oe_o <= 1'b0;
              st_q <= RTAC_ST_RACK;
            end
            else
            begin
              cnt_q <= cnt_q + 3'h1;
              shift_q <= {shift_q[6:0], 1'b0};
              sda_oe_o <= !shift_q[6];
            end
          end
        RTAC_ST_RACK:
          if (scl_rise)
          begin
            nack_q <= sda_i;
            if (!sda_i)
              ptr_q <= ptr_q + 8'h01;
          end
          else if (scl_fall)
          begin
            cnt_q <= 3'h0;
            if (nack_q)
              st_q <= RTAC_ST_IDLE;
            else
            begin
              st_q <= RTAC_ST_RD;
              shift_q <= rdata;
              sda_oe_o <= !rdata[7];
            end
          end
      endcase
    end
  end

  // Open-drain line only ever pulls low
  always_ff @(posedge clk_i)
  begin
    sda_out_q <= 1'b0;
  end

  assign sda_o = sda_out_q;

  // ****************************************
  // Rate selection and lock judgement
  // ****************************************
  logic [3:0] std_nib;
  logic [3:0] div0_d, div1_d;

  assign std_nib = std_q[RTAC_STD_NIB_LSB +: 4];

  always_comb
  begin
    div0_d = RTAC_DIV_1;
    div1_d = RTAC_DIV_1;
    unique case (std_nib)
      RTAC_STD_AUTO_ETH: div0_d = RTAC_DIV_8;
      RTAC_STD_FC: div0_d = RTAC_DIV_124;
      RTAC_STD_IB:
      begin
        div0_d = RTAC_DIV_124;
        div1_d = RTAC_DIV_124;
      end
      RTAC_STD_4:
      begin
        div0_d = RTAC_DIV_24;
        div1_d = RTAC_DIV_24;
      end
      RTAC_STD_SONET:
      begin
        div0_d = RTAC_DIV_14;
        div1_d = RTAC_DIV_14;
      end
      RTAC_STD_6:
      begin
        div0_d = RTAC_DIV_1248;
        div1_d = RTAC_DIV_1248;
      end
      RTAC_STD_A:
      begin
        div0_d = RTAC_DIV_2;
        div1_d = RTAC_DIV_2;
      end
      default: ;
    endcase
  end

  logic [RTAC_COUNT_W-1:0] exp_cnt, diff;
  logic [3:0] tol_sel;

  assign exp_cnt = meas_group_i ? {g1_hi_q[6:0], g1_lo_q} : {g0_hi_q[6:0], g0_lo_q};
  assign tol_sel = meas_group_i ? tol_q[RTAC_TOL_G1_LSB +: 4] : tol_q[RTAC_TOL_G0_LSB +: 4];
  assign diff = (meas_count_i >= exp_cnt) ? meas_count_i - exp_cnt : exp_cnt - meas_count_i;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      tune_set_o <= 4'h0;
      auto_rate_o <= 1'b0;
      div_group0_o <= RTAC_DIV_1;
      div_group1_o <= RTAC_DIV_1;
      count_manual_o <= 2'h0;
      freq_lock_o <= 1'b0;
    end
    else
    begin
      tune_set_o <= std_nib;
      auto_rate_o <= (std_nib == RTAC_STD_AUTO_ETH);
      div_group0_o <= div0_d;
      div_group1_o <= div1_d;
      count_manual_o <= {g1_hi_q[RTAC_MANUAL_BIT], g0_hi_q[RTAC_MANUAL_BIT]};
      if (meas_valid_i)
        freq_lock_o <= (diff <= {11'h000, tol_sel});
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_addr_hold: assert property (cap_done_q && $past(cap_done_q) |-> $stable(slave_addr_o))
    else $error("slave address changed after capture");
  // Sampled reset keeps the release edge from starting a false attempt
  a_addr_strap: assert property (!rst_i && !cap_done_q
      && !(bus_mode_select_pin_i && load_gate_i)
      |=> slave_addr_o == RTAC_ADDR_BASE + {3'h0, $past(addr_strap_inputs_i)})
    else $error("strapped address wrong");
  a_addr_test: assert property (!rst_i && !cap_done_q
      && bus_mode_select_pin_i && load_gate_i
      |=> slave_addr_o == RTAC_ADDR_BASE)
    else $error("test address not taken");
  a_read_dir: assert property ($rose(st_q == RTAC_ST_RD) && $past(st_q) == RTAC_ST_AACK
      |-> rw_q == RTAC_DIR_READ)
    else $error("read entered on write address");
  a_reg_write: assert property (wr_en && ptr_q == RTAC_OFS_TOL |=> tol_q == $past(byte_in))
    else $error("tolerance write lost");
  a_div_auto: assert property (!rst_i && std_nib == RTAC_STD_AUTO_ETH
      ##1 std_nib == RTAC_STD_AUTO_ETH
      |-> div_group0_o == RTAC_DIV_8 && auto_rate_o)
    else $error("auto ethernet divider wrong");
  a_div_shared: assert property (std_nib == RTAC_STD_IB |=> div_group0_o == div_group1_o)
    else $error("shared divider mismatch");
  a_lock_tol: assert property (meas_valid_i && diff > {11'h000, tol_sel} |=> !freq_lock_o)
    else $error("lock declared outside tolerance");
  a_lock_hit: assert property (meas_valid_i && meas_count_i == exp_cnt |=> freq_lock_o)
    else $error("exact count not locked");

  c_read: cover property (st_q == RTAC_ST_RACK ##[1:400] st_q == RTAC_ST_RD);
  c_write: cover property (wr_en);
  c_lock: cover property (meas_valid_i ##1 freq_lock_o);
  c_test_addr: cover property (!cap_done_q && bus_mode_select_pin_i && load_gate_i);

endmodule // rtac_config

`default_nettype wire

// ==== tb/rtac_smb_master.sv ====
// Serial bus master model that configures the retimer registers
`timescale 1ns/1ps
`default_nettype none
module rtac_smb_master
  import rtac_pkg::*;
(
  input wire logic clk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_oe_o
);
  initial
  begin
    scl_o = 1'b1;
    sda_oe_o = 1'b0;
  end
  task automatic half();
    repeat (4) @(posedge clk_i);
  endtask
  task automatic start();
    sda_oe_o <= 1'b0;
    half();
    scl_o <= 1'b1;
    half();
    sda_oe_o <= 1'b1;
    half();
    scl_o <= 1'b0;
    half();
  endtask
  task automatic stop();
    sda_oe_o <= 1'b1;
    half();
    scl_o <= 1'b1;
    half();
    sda_oe_o <= 1'b0;
    half();
  endtask
  // Data changes only while the clock is low
  task automatic bit_io(input logic b, output logic r);
    sda_oe_o <= ~b;
    half();
    scl_o <= 1'b1;
    half();
    r = sda_i;
    half();
    scl_o <= 1'b0;
    half();
  endtask
  task automatic byte_io(input logic [7:0] d, input logic ai, output logic [7:0] q,
                         output logic ao);
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], q[i]);
    bit_io(ai, ao);
  endtask
  task automatic reg_write(input logic [6:0] a, input logic [7:0] o, input logic [7:0] d,
                           output logic ack);
    logic [7:0] q;
    logic n0;
    logic n1;
    logic n2;
    start();
    byte_io({a, RTAC_DIR_WRITE}, 1'b1, q, n0);
    byte_io(o, 1'b1, q, n1);
    byte_io(d, 1'b1, q, n2);
    stop();
    ack = ~(n0 | n1 | n2);
  endtask
  task automatic reg_read(input logic [6:0] a, input logic [7:0] o, output logic [7:0] d,
                          output logic ack);
    logic [7:0] q;
    logic n0;
    logic n1;
    logic n2;
    logic x;
    start();
    byte_io({a, RTAC_DIR_WRITE}, 1'b1, q, n0);
    byte_io(o, 1'b1, q, n1);
    start();
    byte_io({a, RTAC_DIR_READ}, 1'b1, q, n2);
    byte_io(8'hff, 1'b1, d, x);
    stop();
    ack = ~(n0 | n1 | n2);
  endtask
endmodule // rtac_smb_master
`default_nettype wire

// ==== tb/retimer_addr_rate_config_test.sv ====
// Register-level test of the retimer address and rate configuration block
`timescale 1ns/1ps
`default_nettype none
module retimer_addr_rate_config_test
  import rtac_pkg::*;
;
  localparam int LIMIT = 60000;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [3:0] strap = 4'h0;
  logic mode = 1'b1;
  logic gate = 1'b0;
  logic mv = 1'b0;
  logic mg = 1'b0;
  logic [14:0] mc = 15'h0000;
  wire logic scl;
  wire logic mst_oe;
  wire logic dut_oe;
  wire logic sda_drv;
  wire logic sda_line;
  logic [6:0] saddr;
  logic [3:0] tune;
  logic auto_r;
  logic [3:0] div0;
  logic [3:0] div1;
  logic [1:0] manual;
  logic lock;
  logic [6:0] cur = 7'h18;
  logic ack;
  int errors = 0;
  int n_tests = 0;
  int cycles = 0;
  logic [11:0] std_tbl [11] = '{12'h081, 12'h171, 12'h277, 12'h466, 12'h555, 12'h6ff,
                                12'h711, 12'h811, 12'ha22, 12'hc11, 12'hd11};
  // Open-drain data line with pull-up
  assign sda_line = ~(mst_oe | dut_oe);
  rtac_config i_dut (.clk_i(clk_i), .rst_i(rst_i), .addr_strap_inputs_i(strap),
    .bus_mode_select_pin_i(mode), .load_gate_i(gate), .serial_clock_line_i(scl),
    .sda_i(sda_line), .sda_o(sda_drv), .sda_oe_o(dut_oe), .meas_valid_i(mv),
    .meas_group_i(mg), .meas_count_i(mc), .slave_addr_o(saddr), .tune_set_o(tune),
    .auto_rate_o(auto_r), .div_group0_o(div0), .div_group1_o(div1),
    .count_manual_o(manual), .freq_lock_o(lock));
  rtac_smb_master i_mst (.clk_i(clk_i), .sda_i(sda_line), .scl_o(scl), .sda_oe_o(mst_oe));
  initial
  begin
    forever #10 clk_i = ~clk_i;
  end
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == LIMIT)
    begin
      errors++;
      stop_test();
    end
  end
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic do_reset(input logic [3:0] s, input logic g);
    rst_i <= 1'b1;
    strap <= s;
    gate <= g;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask
  task automatic wr(input logic [7:0] o, input logic [7:0] d);
    i_mst.reg_write(cur, o, d, ack);
    check("write ack", ack, 1'b1);
  endtask
  task automatic rd(input logic [7:0] o, input logic [7:0] exp);
    logic [7:0] q;
    i_mst.reg_read(cur, o, q, ack);
    check("read ack", ack, 1'b1);
    check("read data", q, exp);
  endtask
  task automatic meas(input logic g, input logic [14:0] c, input logic e);
    mv <= 1'b1;
    mg <= g;
    mc <= c;
    @(posedge clk_i);
    mv <= 1'b0;
    repeat (2) @(posedge clk_i);
    check("freq lock", lock, e);
  endtask
  // ****************************************
  // Test sequence
  // ****************************************
  initial
  begin
    do_reset(4'ha, 1'b0);
    check("slave addr", saddr, 7'h22);
    check("data pin", sda_drv, 1'b0);
    strap <= 4'h5;
    repeat (3) @(posedge clk_i);
    check("addr held", saddr, 7'h22);
    i_mst.reg_write(7'h18, RTAC_OFS_TOL, 8'h11, ack);
    check("foreign ack", ack, 1'b0);
    cur = 7'h22;
    rd(RTAC_OFS_STD_SEL, RTAC_RST_STD_SEL);
    rd(RTAC_OFS_TOL, RTAC_RST_TOL);
    wr(8'hff, 8'h00);
    wr(RTAC_OFS_G0_LO, 8'h00);
    wr(RTAC_OFS_G0_HI, 8'hb2);
    wr(RTAC_OFS_G1_LO, 8'h90);
    wr(RTAC_OFS_G1_HI, 8'hb3);
    wr(RTAC_OFS_TOL, 8'h3f);
    wr(8'h0a, 8'h0c);
    wr(8'h0a, 8'h00);
    rd(RTAC_OFS_G0_LO, 8'h00);
    rd(RTAC_OFS_G0_HI, 8'hb2);
    rd(RTAC_OFS_G1_LO, 8'h90);
    rd(RTAC_OFS_G1_HI, 8'hb3);
    rd(RTAC_OFS_TOL, 8'h3f);
    rd(8'h10, RTAC_UNMAPPED_RD);
    check("manual flags", manual, 2'b11);
    $display("test registers done");
    for (int i = 0; i < 11; i++)
    begin
      wr(RTAC_OFS_STD_SEL, {std_tbl[i][11:8], 4'h6});
      repeat (2) @(posedge clk_i);
      check("tune set", tune, std_tbl[i][11:8]);
      check("auto rate", auto_r, std_tbl[i][11:8] == 4'h0);
      check("div group0", div0, std_tbl[i][7:4]);
      check("div group1", div1, std_tbl[i][3:0]);
    end
    rd(RTAC_OFS_STD_SEL, 8'hd6);
    $display("test standards done");
    meas(1'b0, 15'd12800, 1'b1);
    meas(1'b0, 15'd12815, 1'b1);
    meas(1'b0, 15'd12816, 1'b0);
    meas(1'b0, 15'd12785, 1'b1);
    meas(1'b0, 15'd12784, 1'b0);
    meas(1'b1, 15'd13203, 1'b1);
    meas(1'b1, 15'd13204, 1'b0);
    meas(1'b1, 15'd13197, 1'b1);
    $display("test lock done");
    do_reset(4'hf, 1'b0);
    check("top addr", saddr, 7'h27);
    cur = 7'h27;
    rd(RTAC_OFS_G1_HI, RTAC_RST_COUNT);
    do_reset(4'h5, 1'b1);
    check("test addr", saddr, 7'h18);
    cur = 7'h18;
    rd(RTAC_OFS_TOL, RTAC_RST_TOL);
    mode <= 1'b0;
    do_reset(4'h3, 1'b1);
    check("master mode addr", saddr, 7'h1b);
    $display("test addressing done");
    stop_test();
  end
endmodule // retimer_addr_rate_config_test
`default_nettype wire
